// ==== slm_pkg.sv ====
package slm_pkg;

  // Register offsets
  localparam logic [7:0] OFS_STATUS      = 8'h06;
  localparam logic [7:0] OFS_MODE        = 8'h08;
  localparam logic [7:0] OFS_CONFIG      = 8'h09;
  localparam logic [7:0] OFS_CONTROL_C   = 8'h0a;
  localparam logic [7:0] OFS_REF_SETUP   = 8'h0f;
  localparam logic [7:0] OFS_SLICE       = 8'h15;
  localparam logic [7:0] OFS_EQ          = 8'h16;
  localparam logic [7:0] OFS_IND_DATA    = 8'h36;
  localparam logic [7:0] OFS_IND_CTRL    = 8'h74;

  // Reset values
  localparam logic [7:0] RST_MODE        = 8'h00;
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_CONTROL_C   = 8'h05;
  localparam logic [7:0] RST_REF_SETUP   = 8'h00;
  localparam logic [7:0] RST_SLICE       = 8'h00;
  localparam logic [7:0] RST_EQ          = 8'h00;
  localparam logic [7:0] RST_IND_DATA    = 8'h00;
  localparam logic [7:0] RST_IND_CTRL    = 8'h00;
  localparam logic [7:0] RST_THRESHOLD   = 8'h00;

  // Field positions
  localparam int STS_SIGNAL_LOSS_BIT     = 0;
  localparam int STS_LOCK_LOST_BIT       = 1;
  localparam int STS_STICKY_BIT          = 2;
  localparam int MODE_STICKY_CLR_BIT     = 2;
  localparam int MODE_SEL_LSB            = 4;
  localparam int CFG_DET_PDN_BIT         = 3;
  localparam int CFG_STICKY_OUT_BIT      = 4;
  localparam int CTC_REF_PDN_BIT         = 2;
  localparam int EQ_TERM_FLOAT_BIT       = 7;
  localparam int EQ_MANUAL_BIT           = 6;
  localparam int IND_STROBE_BIT          = 4;

  // Field values
  localparam logic [2:0] MODE_REF_ASSISTED = 3'h3;
  localparam logic [2:0] IND_SEL_THRESHOLD = 3'h1;
  localparam logic [2:0] IND_SEL_MEASURE   = 3'h7;
  localparam logic [7:0] THR_FINE_LIMIT    = 8'h40;
  localparam logic [7:0] THR_MAX_MV        = 8'h80;

  // Lock windows in ppm
  localparam int LOCK_ENTER_PPM          = 250;
  localparam int LOCK_EXIT_PPM           = 1000;

  // Serial bus slave address, upper six bits
  localparam logic [5:0] BUS_ADDR_HI     = 6'h20;

endpackage

// ==== slm_sync.sv ====
module slm_sync
  import slm_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  // Raw and filtered level
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once the last two stages agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          q_o[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          q_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate

endmodule

// ==== slm_hyst.sv ====
module slm_hyst
  import slm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Amplitude and threshold
  input  wire logic [7:0] amp_mv_i,
  input  wire logic [7:0] thr_mv_i,
  input  wire logic       pdn_i,
  // Detector result
  output logic            signal_loss_o
);

  logic [8:0] clear_level;

  assign clear_level = {thr_mv_i, 1'b0};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      signal_loss_o <= 1'b0;
    end else if (pdn_i) begin
      // Powered-down detector reports no loss
      signal_loss_o <= 1'b0;
    end else if (!signal_loss_o && (amp_mv_i < thr_mv_i)) begin
      signal_loss_o <= 1'b1;
    end else if (signal_loss_o && ({1'b0, amp_mv_i} >= clear_level)) begin
      signal_loss_o <= 1'b0;
    end
  end

endmodule

// ==== slm_top.sv ====
// What this block does
// - Signal loss sets below threshold, clears only at twice threshold.
// - Loss detector uses absolute amplitude, unaffected by slice offset.
// - Detector active after reset; config bit D3 powers it down.
// - Threshold 0..128 mV loaded from data register on strobe with select 1.
// - Threshold 1 mV steps to 63; above, bit 0 forced zero.
// - Host writes 0x7, 0x17, 0x7; strobe fall loads measured amplitude.
// - Data register takes amplitude only on strobe pulse with select 7.
// - Equalizer adaptive by default, manual setting when software selects.
// - Equalizer bit D7 floats terminations when set, ties to rail when clear.
// - Lock detector has free-running, reference-assisted and sticky modes.
// - Free-running: lock within 250 ppm, then phase loop takes over.
// - Locked and error above 1000 ppm: reassert loss, restart acquisition.
// - Mode field value 3 selects reference-assisted acquisition.
// - Reference mode compares divided clocks with same 250/1000 ppm windows.
// - Sticky lock-loss status set on loss; cleared by writing 1 then 0.
// - Config bit D4 makes lock output mirror sticky bit, else live state.
module slm_top
  import slm_pkg::*;
#(
  parameter int PPM_W = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Serial register bus
  input  wire logic             scl_i,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  input  wire logic             bus_addr_lsb_i,
  // Front-end measurement
  input  wire logic [7:0]       amp_mv_i,
  input  wire logic [PPM_W-1:0] data_err_ppm_i,
  input  wire logic [PPM_W-1:0] ref_err_ppm_i,
  // Status pins
  output logic                  signal_loss_o,
  output logic                  lock_lost_o,
  // Loop control
  output logic                  phase_loop_en_o,
  output logic                  freq_acq_restart_o,
  output logic                  reference_assisted_o,
  output logic [1:0]            reference_frequency_range_o,
  output logic [3:0]            data_reference_divide_o,
  output logic                  reference_buffer_powerdown_o,
  output logic [7:0]            control_c_o,
  // Front-end control
  output logic                  signal_detector_powerdown_o,
  output logic [7:0]            slice_o,
  output logic                  eq_manual_o,
  output logic [5:0]            eq_setting_o,
  output logic                  term_float_o
);

  typedef enum logic [3:0] {
    SLM_IDLE, SLM_ADDR, SLM_SUB, SLM_WR, SLM_ACK, SLM_RD, SLM_RACK
  } slm_bus_e;

  typedef enum logic {SLM_ACQUIRE, SLM_LOCKED} slm_lock_e;

  // Register storage
  logic [7:0]       mode_q;
  logic [7:0]       config_q;
  logic [7:0]       control_c_q;
  logic [7:0]       ref_setup_q;
  logic [7:0]       slice_q;
  logic [7:0]       eq_q;
  logic [7:0]       ind_data_q;
  logic [7:0]       ind_ctrl_q;
  logic [7:0]       threshold_q;
  logic             sticky_q;
  // Bus engine
  slm_bus_e         bus_state_q;
  slm_bus_e         ack_next_q;
  logic [7:0]       shift_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       sub_q;
  logic             scl_prev_q;
  logic             sda_prev_q;
  logic             wr_en_q;
  logic [7:0]       wr_addr_q;
  logic [7:0]       wr_data_q;
  logic [1:0]       pin_sync;
  logic             scl_s;
  logic             sda_s;
  logic             bus_start;
  logic             bus_stop;
  logic             scl_rise;
  logic             scl_fall;
  logic [7:0]       rd_byte;
  // Lock detector
  slm_lock_e        lock_state_q;
  logic [PPM_W-1:0] freq_err;
  logic             live_loss;
  logic [1:0]       status_sync;
  logic             strobe_fall;

  // Returns whether an offset names a register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFS_STATUS) || (a == OFS_MODE) || (a == OFS_CONFIG) ||
                (a == OFS_CONTROL_C) || (a == OFS_REF_SETUP) || (a == OFS_SLICE) ||
                (a == OFS_EQ) || (a == OFS_IND_DATA) || (a == OFS_IND_CTRL);
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      OFS_STATUS:    read_reg = {5'h00, sticky_q, status_sync[1], status_sync[0]};
      OFS_MODE:      read_reg = mode_q;
      OFS_CONFIG:    read_reg = config_q;
      OFS_CONTROL_C: read_reg = control_c_q;
      OFS_REF_SETUP: read_reg = ref_setup_q;
      OFS_SLICE:     read_reg = slice_q;
      OFS_EQ:        read_reg = eq_q;
      OFS_IND_DATA:  read_reg = ind_data_q;
      OFS_IND_CTRL:  read_reg = ind_ctrl_q;
      default:       read_reg = 8'h00;
    endcase
  endfunction

  // Upper range drops the 1 mV bit; values above full scale saturate
  function automatic logic [7:0] encode_thr(input logic [7:0] mv);
    if (mv > THR_MAX_MV) begin
      encode_thr = THR_MAX_MV;
    end else if (mv >= THR_FINE_LIMIT) begin
      encode_thr = {mv[7:1], 1'b0};
    end else begin
      encode_thr = mv;
    end
  endfunction

  slm_sync #(
    .W (2)
  ) u_pin_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({scl_i, sda_i}),
    .q_o    (pin_sync)
  );

  assign scl_s     = pin_sync[1];
  assign sda_s     = pin_sync[0];
  assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign bus_stop  = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign scl_rise  = scl_s && !scl_prev_q;
  assign scl_fall  = !scl_s && scl_prev_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Read byte for the current offset, seen by the read path
  always_comb begin
    rd_byte = read_reg(sub_q);
  end

  // Byte-level bus engine; data pin only ever pulls low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o       <= 1'b0;
      bus_state_q <= SLM_IDLE;
      ack_next_q  <= SLM_IDLE;
      shift_q     <= 8'h00;
      bit_cnt_q   <= 4'h0;
      sub_q       <= 8'h00;
      sda_oe_o    <= 1'b0;
      wr_en_q     <= 1'b0;
      wr_addr_q   <= 8'h00;
      wr_data_q   <= 8'h00;
    end else begin
      sda_o   <= 1'b0;
      wr_en_q <= 1'b0;
      if (bus_stop) begin
        bus_state_q <= SLM_IDLE;
        sda_oe_o    <= 1'b0;
      end else if (bus_start) begin
        bus_state_q <= SLM_ADDR;
        bit_cnt_q   <= 4'h0;
        sda_oe_o    <= 1'b0;
      end else begin
        case (bus_state_q)
          SLM_ADDR, SLM_SUB, SLM_WR: begin
            if (scl_rise && bit_cnt_q != 4'h8) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (bus_state_q == SLM_ADDR) begin
                if (shift_q[7:1] == {BUS_ADDR_HI, bus_addr_lsb_i}) begin
                  sda_oe_o    <= 1'b1;
                  bus_state_q <= SLM_ACK;
                  ack_next_q  <= shift_q[0] ? SLM_RD : SLM_SUB;
                end else begin
                  bus_state_q <= SLM_IDLE;
                end
              end else if (bus_state_q == SLM_SUB) begin
                // Unmapped offset: no acknowledge, back to idle
                if (is_mapped(shift_q)) begin
                  sub_q       <= shift_q;
                  sda_oe_o    <= 1'b1;
                  bus_state_q <= SLM_ACK;
                  ack_next_q  <= SLM_WR;
                end else begin
                  bus_state_q <= SLM_IDLE;
                end
              end else begin
                wr_en_q     <= 1'b1;
                wr_addr_q   <= sub_q;
                wr_data_q   <= shift_q;
                sub_q       <= (sub_q == OFS_IND_CTRL) ? sub_q : sub_q + 8'h01;
                sda_oe_o    <= 1'b1;
                bus_state_q <= SLM_ACK;
                ack_next_q  <= SLM_WR;
              end
            end
          end
          SLM_ACK: begin
            if (scl_fall) begin
              bus_state_q <= ack_next_q;
              if (ack_next_q == SLM_RD) begin
                shift_q   <= rd_byte;
                sda_oe_o  <= !rd_byte[7];
                bit_cnt_q <= 4'h1;
              end else begin
                sda_oe_o  <= 1'b0;
                bit_cnt_q <= 4'h0;
              end
            end
          end
          SLM_RD: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h8) begin
                sda_oe_o    <= 1'b0;
                bus_state_q <= SLM_RACK;
              end else begin
                shift_q   <= {shift_q[6:0], 1'b0};
                sda_oe_o  <= !shift_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          SLM_RACK: begin
            // Past the top offset the last register repeats
            if (scl_rise) begin
              if (sda_s) begin
                bus_state_q <= SLM_IDLE;
              end else begin
                sub_q       <= (sub_q == OFS_IND_CTRL) ? sub_q : sub_q + 8'h01;
                bus_state_q <= SLM_ACK;
                ack_next_q  <= SLM_RD;
              end
            end
          end
          default: begin
            bus_state_q <= SLM_IDLE;
            sda_oe_o    <= 1'b0;
          end
        endcase
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q      <= RST_MODE;
      config_q    <= RST_CONFIG;
      control_c_q <= RST_CONTROL_C;
      ref_setup_q <= RST_REF_SETUP;
      slice_q     <= RST_SLICE;
      eq_q        <= RST_EQ;
      ind_ctrl_q  <= RST_IND_CTRL;
    end else if (wr_en_q) begin
      case (wr_addr_q)
        OFS_MODE:      mode_q      <= wr_data_q;
        OFS_CONFIG:    config_q    <= wr_data_q;
        OFS_CONTROL_C: control_c_q <= wr_data_q;
        OFS_REF_SETUP: ref_setup_q <= wr_data_q;
        OFS_SLICE:     slice_q     <= wr_data_q;
        OFS_EQ:        eq_q        <= wr_data_q;
        OFS_IND_CTRL:  ind_ctrl_q  <= wr_data_q;
        default:       ;
      endcase
    end
  end

  // Strobe high to low, seen as a control write that drops bit 4
  assign strobe_fall = wr_en_q && (wr_addr_q == OFS_IND_CTRL) &&
                       ind_ctrl_q[IND_STROBE_BIT] && !wr_data_q[IND_STROBE_BIT];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ind_data_q  <= RST_IND_DATA;
      threshold_q <= RST_THRESHOLD;
    end else begin
      if (wr_en_q && wr_addr_q == OFS_IND_DATA) begin
        ind_data_q <= wr_data_q;
      end else if (strobe_fall && wr_data_q[2:0] == IND_SEL_MEASURE) begin
        ind_data_q <= amp_mv_i;
      end
      if (strobe_fall && wr_data_q[2:0] == IND_SEL_THRESHOLD) begin
        threshold_q <= encode_thr(ind_data_q);
      end
    end
  end

  // Amplitude input is taken before any slice offset is applied
  slm_hyst u_hyst (
    .clk_i         (clk_i),
    .nrst_i        (nrst_i),
    .amp_mv_i      (amp_mv_i),
    .thr_mv_i      (threshold_q),
    .pdn_i         (config_q[CFG_DET_PDN_BIT]),
    .signal_loss_o (signal_loss_o)
  );

  // Lock detector: error source follows the mode field
  assign freq_err = (mode_q[MODE_SEL_LSB +: 3] == MODE_REF_ASSISTED) ? ref_err_ppm_i : data_err_ppm_i;
  assign live_loss = (lock_state_q == SLM_ACQUIRE);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_state_q       <= SLM_ACQUIRE;
      freq_acq_restart_o <= 1'b0;
    end else begin
      freq_acq_restart_o <= 1'b0;
      case (lock_state_q)
        SLM_ACQUIRE: begin
          if (freq_err <= PPM_W'(LOCK_ENTER_PPM)) begin
            lock_state_q <= SLM_LOCKED;
          end
        end
        SLM_LOCKED: begin
          if (freq_err > PPM_W'(LOCK_EXIT_PPM)) begin
            lock_state_q       <= SLM_ACQUIRE;
            freq_acq_restart_o <= 1'b1;
          end
        end
        default: lock_state_q <= SLM_ACQUIRE;
      endcase
    end
  end

  // Sticky flag: clear on 1-to-0 of mode bit 2, a fresh loss wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sticky_q <= 1'b0;
    end else if (lock_state_q == SLM_LOCKED && freq_err > PPM_W'(LOCK_EXIT_PPM)) begin
      sticky_q <= 1'b1;
    end else if (wr_en_q && wr_addr_q == OFS_MODE && mode_q[MODE_STICKY_CLR_BIT] &&
                 !wr_data_q[MODE_STICKY_CLR_BIT]) begin
      sticky_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_lost_o     <= 1'b1;
      phase_loop_en_o <= 1'b0;
    end else begin
      lock_lost_o     <= config_q[CFG_STICKY_OUT_BIT] ? sticky_q : live_loss;
      phase_loop_en_o <= !live_loss;
    end
  end

  slm_sync #(
    .W (2)
  ) u_status_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({live_loss, signal_loss_o}),
    .q_o    (status_sync)
  );

  // Registered copies of control fields for the analog side
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reference_assisted_o         <= 1'b0;
      reference_frequency_range_o  <= 2'h0;
      data_reference_divide_o      <= 4'h0;
      reference_buffer_powerdown_o <= 1'b0;
      control_c_o                  <= RST_CONTROL_C;
      signal_detector_powerdown_o  <= 1'b0;
      slice_o                      <= RST_SLICE;
      eq_manual_o                  <= 1'b0;
      eq_setting_o                 <= 6'h00;
      term_float_o                 <= 1'b0;
    end else begin
      reference_assisted_o         <= (mode_q[MODE_SEL_LSB +: 3] == MODE_REF_ASSISTED);
      reference_frequency_range_o  <= ref_setup_q[5:4];
      data_reference_divide_o      <= ref_setup_q[3:0];
      reference_buffer_powerdown_o <= control_c_q[CTC_REF_PDN_BIT];
      control_c_o                  <= control_c_q;
      signal_detector_powerdown_o  <= config_q[CFG_DET_PDN_BIT];
      slice_o                      <= slice_q;
      eq_manual_o                  <= eq_q[EQ_MANUAL_BIT];
      eq_setting_o                 <= eq_q[5:0];
      term_float_o                 <= eq_q[EQ_TERM_FLOAT_BIT];
    end
  end

endmodule

// ==== slm_top_assertions.sv ====
module slm_chk
  import slm_pkg::*;
#(
  parameter int PPM_W = 16
) (
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic [PPM_W-1:0] data_err_ppm_i,
  input wire logic [PPM_W-1:0] ref_err_ppm_i,
  input wire logic             signal_loss_o,
  input wire logic             phase_loop_en_o,
  input wire logic             freq_acq_restart_o,
  input wire logic             reference_assisted_o,
  input wire logic             signal_detector_powerdown_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_free_lock: assert property ((!reference_assisted_o && data_err_ppm_i <= 250)[*4] |-> phase_loop_en_o)
    else $error("no lock in free mode");
  a_free_unlock: assert property ((!reference_assisted_o && data_err_ppm_i > 1000)[*4] |-> !phase_loop_en_o)
    else $error("lock kept in free mode");
  a_ref_lock: assert property ((reference_assisted_o && ref_err_ppm_i <= 250)[*4] |-> phase_loop_en_o)
    else $error("no lock in reference mode");
  a_ref_unlock: assert property ((reference_assisted_o && ref_err_ppm_i > 1000)[*4] |-> !phase_loop_en_o)
    else $error("lock kept in reference mode");
  a_restart_pulse: assert property (freq_acq_restart_o |=> !freq_acq_restart_o)
    else $error("restart longer than one cycle");
  a_restart_drop: assert property (freq_acq_restart_o |-> ##[0:2] !phase_loop_en_o)
    else $error("restart without lock drop");
  a_drop_cause: assert property ($fell(phase_loop_en_o)
      |-> (freq_acq_restart_o || $past(freq_acq_restart_o) || $past(freq_acq_restart_o, 2)))
    else $error("lock dropped without restart");
  a_pdn_quiet: assert property (signal_detector_powerdown_o[*3] |-> !signal_loss_o)
    else $error("loss flagged while powered down");
endmodule

bind slm_top slm_chk #(.PPM_W(PPM_W)) u_chk (
  .clk_i                       (clk_i),
  .nrst_i                      (nrst_i),
  .data_err_ppm_i              (data_err_ppm_i),
  .ref_err_ppm_i               (ref_err_ppm_i),
  .signal_loss_o               (signal_loss_o),
  .phase_loop_en_o             (phase_loop_en_o),
  .freq_acq_restart_o          (freq_acq_restart_o),
  .reference_assisted_o        (reference_assisted_o),
  .signal_detector_powerdown_o (signal_detector_powerdown_o)
);

// ==== slm_far_end.sv ====
module slm_far_end
  import slm_pkg::*;
#(
  parameter int PPM_W = 16
) (
  // Clock
  input  wire logic             clk_i,
  // Commanded line conditions
  input  wire logic [7:0]       amp_set_i,
  input  wire logic [PPM_W-1:0] data_set_i,
  input  wire logic [PPM_W-1:0] ref_set_i,
  input  wire logic             ref_pdn_i,
  // Front-end measurement
  output logic      [7:0]       amp_mv_o,
  output logic      [PPM_W-1:0] data_err_o,
  output logic      [PPM_W-1:0] ref_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    amp_mv_o = 8'hc8;
    data_err_o = '1;
    ref_err_o = '1;
  end
  always @(posedge clk_i) begin
    amp_mv_o <= #1 amp_set_i;
    data_err_o <= #1 data_set_i;
    // Unpowered buffer sees no reference edges, so the error is huge
    ref_err_o <= #1 ref_pdn_i ? '1 : ref_set_i;
  end
endmodule

// ==== tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import slm_pkg::*;
  localparam int H = 10;
  localparam logic [7:0] ADW = {BUS_ADDR_HI, 1'b1, 1'b0};
  localparam logic [7:0] ADR = {BUS_ADDR_HI, 1'b1, 1'b1};
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        scl_m = 1'b1;
  logic        sda_m = 1'b1;
  logic [7:0]  amp_set = 8'hc8;
  logic [15:0] data_set = 16'h07d0;
  logic [15:0] ref_set = 16'h07d0;
  logic [7:0]  amp;
  logic [15:0] derr, rerr;
  logic        sda_oe, loss, lock_lost, ple, ra, rpdn, pdn, eqm, term;
  logic [1:0]  rng;
  logic [3:0]  div;
  logic [7:0]  ctc, slc;
  logic [5:0]  eqs;
  wire         sda_w = sda_m & !sda_oe;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [7:0]  k_seq [3] = '{8'h07, 8'h17, 8'h07};

  always #12.5 clk_i = ~clk_i;

  slm_far_end #(.PPM_W(16)) u_far (.clk_i(clk_i), .amp_set_i(amp_set), .data_set_i(data_set),
    .ref_set_i(ref_set), .ref_pdn_i(rpdn), .amp_mv_o(amp), .data_err_o(derr), .ref_err_o(rerr));

  slm_top #(.PPM_W(16)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_m), .sda_i(sda_w), .sda_o(),
    .sda_oe_o(sda_oe), .bus_addr_lsb_i(1'b1), .amp_mv_i(amp), .data_err_ppm_i(derr),
    .ref_err_ppm_i(rerr), .signal_loss_o(loss), .lock_lost_o(lock_lost), .phase_loop_en_o(ple),
    .freq_acq_restart_o(), .reference_assisted_o(ra), .reference_frequency_range_o(rng),
    .data_reference_divide_o(div), .reference_buffer_powerdown_o(rpdn), .control_c_o(ctc),
    .signal_detector_powerdown_o(pdn), .slice_o(slc), .eq_manual_o(eqm), .eq_setting_o(eqs),
    .term_float_o(term));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Generous: whole sequence needs about 23k cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      wrap_up;
    end
  end

  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // Data moves 3 clocks after SCL falls so the filter never sees a false START
  task automatic bit_x(input logic b, output logic r);
    w(3);
    sda_m = b;
    w(H);
    scl_m = 1'b1;
    w(H);
    r = sda_w;
    scl_m = 1'b0;
  endtask
  task automatic start_c;
    w(3);
    sda_m = 1'b1;
    w(H);
    scl_m = 1'b1;
    w(H);
    sda_m = 1'b0;
    w(H);
    scl_m = 1'b0;
  endtask
  task automatic stop_c;
    w(3);
    sda_m = 1'b0;
    w(H);
    scl_m = 1'b1;
    w(H);
    sda_m = 1'b1;
    w(H);
  endtask
  task automatic tx(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    start_c;
    tx(ADW, k);
    tx(a, k);
    tx(d, k);
    stop_c;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic       k;
    logic [7:0] q;
    start_c;
    tx(ADW, k);
    tx(a, k);
    start_c;
    tx(ADR, k);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, q[i]);
    bit_x(1'b1, k);
    stop_c;
    chk(q, e);
  endtask
  task automatic ampc(input logic [7:0] a, input logic e);
    amp_set = a;
    w(8);
    chk({7'h0, loss}, {7'h0, e});
  endtask
  task automatic lk(input logic [15:0] d, input logic [15:0] r, input logic [7:0] e);
    data_set = d;
    ref_set = r;
    w(8);
    chk({6'h0, lock_lost, ple}, e);
  endtask

  initial begin
    logic k;
    repeat (2) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    w(4);
    chk(ctc, RST_CONTROL_C);
    rdc(OFS_CONTROL_C, RST_CONTROL_C);
    rdc(OFS_EQ, RST_EQ);
    start_c;
    tx(ADW, k);
    tx(8'h20, k);
    stop_c;
    chk({7'h0, k}, 8'h01);
    $display("test reset done");
    lk(16'd2000, 16'd2000, 8'h02);
    lk(16'd200, 16'd2000, 8'h01);
    lk(16'd600, 16'd2000, 8'h01);
    lk(16'd1001, 16'd2000, 8'h02);
    rdc(OFS_STATUS, 8'h06);
    lk(16'd250, 16'd2000, 8'h01);
    rdc(OFS_STATUS, 8'h04);
    wr(OFS_CONFIG, 8'h10);
    lk(16'd250, 16'd2000, 8'h03);
    wr(OFS_MODE, 8'h04);
    wr(OFS_MODE, 8'h00);
    lk(16'd250, 16'd2000, 8'h01);
    rdc(OFS_STATUS, 8'h00);
    wr(OFS_CONFIG, 8'h00);
    $display("test free lock done");
    wr(OFS_REF_SETUP, 8'h2b);
    wr(OFS_MODE, 8'h30);
    w(4);
    chk({2'h0, rng, div}, 8'h2b);
    chk({7'h0, ra}, 8'h01);
    lk(16'd250, 16'd100, 8'h02);
    wr(OFS_CONTROL_C, 8'h01);
    lk(16'd250, 16'd1500, 8'h02);
    chk(ctc, 8'h01);
    chk({7'h0, rpdn}, 8'h00);
    lk(16'd2000, 16'd100, 8'h01);
    lk(16'd250, 16'd1200, 8'h02);
    wr(OFS_MODE, 8'h00);
    lk(16'd250, 16'd1200, 8'h01);
    $display("test reference lock done");
    wr(OFS_EQ, 8'hca);
    w(4);
    chk({term, eqm, eqs}, 8'hca);
    wr(OFS_EQ, 8'h0f);
    w(4);
    chk({term, eqm, eqs}, 8'h0f);
    $display("test equalizer done");
    amp_set = 8'h5a;
    foreach (k_seq[i]) wr(OFS_IND_CTRL, k_seq[i]);
    rdc(OFS_IND_DATA, 8'h5a);
    amp_set = 8'h33;
    wr(OFS_IND_CTRL, 8'h01);
    wr(OFS_IND_CTRL, 8'h11);
    wr(OFS_IND_CTRL, 8'h01);
    rdc(OFS_IND_DATA, 8'h5a);
    ampc(8'h33, 1'b1);
    ampc(8'd179, 1'b1);
    ampc(8'd180, 1'b0);
    $display("test measurement done");
    wr(OFS_IND_CTRL, 8'h21);
    wr(OFS_IND_DATA, 8'd69);
    wr(OFS_IND_CTRL, 8'h31);
    wr(OFS_IND_CTRL, 8'h21);
    wr(OFS_SLICE, 8'h7f);
    ampc(8'd68, 1'b0);
    ampc(8'd67, 1'b1);
    ampc(8'd135, 1'b1);
    ampc(8'd136, 1'b0);
    chk(slc, 8'h7f);
    wr(OFS_CONFIG, 8'h08);
    ampc(8'd10, 1'b0);
    chk({7'h0, pdn}, 8'h01);
    wr(OFS_CONFIG, 8'h00);
    ampc(8'd10, 1'b1);
    $display("test threshold done");
    wrap_up;
  end

endmodule
